//--- hw/mtm_bank.sv
// Top: machine-check, thermal and feature-enable register bank
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module mtm_bank
    import mtm_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              nrst,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr_stb,
    input  wire logic              rd_stb,
    output logic      [DATA_W-1:0] rdata,
    input  wire logic              mc_error,
    input  wire logic [SNAP_W-1:0] flags_word_in,
    input  wire logic [SNAP_W-1:0] instruction_pointer_in,
    input  wire logic              ds_page_fault,
    input  wire logic              thermal_hot,
    output logic                   irq,
    output logic                   shutdown_req,
    output logic                   clk_stop,
    output logic      [TGT_W-1:0]  thermal_target,
    output logic                   fast_strings_en,
    output logic                   fopcode_compat_en
);

    // ****************************************
    // Declarations
    // ****************************************
    logic [SNAP_W-1:0]    mc_flags_snapshot_q;
    logic [SNAP_W-1:0]    mc_ip_snapshot_q;
    logic                 debug_store_fault_flag_q;
    logic [CM_DUTY_W:0]   clock_throttle_control_q;
    logic [1:0]           thermal_irq_control_q;
    logic                 hot_now_q;
    logic                 hot_log_q;
    logic [TGT_W-1:0]     thermal_target_control_q;
    logic [FE_FOP_BIT:0]  feature_enable_bits_q;
    logic [DATA_W-1:0]    rdata_q;
    logic                 shutdown_q;

    logic                 wr_flags;
    logic                 wr_ip;
    logic                 wr_misc;
    logic                 wr_cm;
    logic                 wr_ti;
    logic                 wr_ts;
    logic                 wr_tgt;
    logic                 wr_fe;
    logic                 wr_mask;
    logic                 rd_stat;
    logic                 clr_ds;
    logic                 clr_log;
    logic                 rise_hot;
    logic                 fall_hot;
    logic [EV_W-1:0]      events;
    logic [EV_W-1:0]      evt_stat;
    logic [EV_W-1:0]      evt_mask;
    logic                 irq_q;
    logic                 clk_stop_q;
    logic [DATA_W-1:0]    rd_mux;

    // ****************************************
    // Helpers
    // ****************************************
    // One strobe qualified by one offset
    function automatic logic hit(
        input logic              stb,
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] off
    );
        hit = stb && (a == off);
    endfunction : hit

    // Zero written to a status bit clears it; a one is ignored
    function automatic logic zero_clear(
        input logic wr,
        input logic bit_val
    );
        zero_clear = wr && !bit_val;
    endfunction : zero_clear

    // ****************************************
    // Write decode
    // ****************************************
    always_comb
    begin
        wr_flags = hit(wr_stb, addr, OFF_MC_FLAGS);
        wr_ip    = hit(wr_stb, addr, OFF_MC_IP);
        wr_misc  = hit(wr_stb, addr, OFF_MC_MISC);
        wr_cm    = hit(wr_stb, addr, OFF_CLK_THR);
        wr_ti    = hit(wr_stb, addr, OFF_THERM_IRQ);
        wr_ts    = hit(wr_stb, addr, OFF_THERM_STAT);
        wr_tgt   = hit(wr_stb, addr, OFF_THERM_TGT);
        wr_fe    = hit(wr_stb, addr, OFF_FEATURES);
        wr_mask  = hit(wr_stb, addr, OFF_EVT_MASK);
        clr_ds   = zero_clear(wr_misc, wdata[MISC_DS_BIT]);
        clr_log  = zero_clear(wr_ts, wdata[TS_LOG_BIT]);
    end

    // ****************************************
    // Read decode
    // ****************************************
    // Only a real read strobe may clear the event status
    always_comb
    begin
        rd_stat  = hit(rd_stb, addr, OFF_EVT_STAT);
    end

    // ****************************************
    // Machine-check snapshots
    // ****************************************
    // Capture beats a clearing write in the same cycle
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            mc_flags_snapshot_q <= SNAP_RST;
        else if (mc_error)
            mc_flags_snapshot_q <= flags_word_in;
        else if (wr_flags)
            mc_flags_snapshot_q <= clear_only(mc_flags_snapshot_q,
                                              wdata[SNAP_W-1:0]);
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            mc_ip_snapshot_q <= SNAP_RST;
        else if (mc_error)
            mc_ip_snapshot_q <= instruction_pointer_in;
        else if (wr_ip)
            mc_ip_snapshot_q <= clear_only(mc_ip_snapshot_q,
                                           wdata[SNAP_W-1:0]);
    end

    // ****************************************
    // Debug-store fault and shutdown
    // ****************************************
    // Writing zero clears; a fault in the same cycle keeps it set
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            debug_store_fault_flag_q <= 1'b0;
        else if (ds_page_fault)
            debug_store_fault_flag_q <= 1'b1;
        else if (clr_ds)
            debug_store_fault_flag_q <= 1'b0;
    end

    // Held as long as the flag stands; only software ends it
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            shutdown_q <= 1'b0;
        else
            shutdown_q <= debug_store_fault_flag_q || ds_page_fault;
    end

    // ****************************************
    // Clock modulation
    // ****************************************
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            clock_throttle_control_q <= CM_RST;
        else if (wr_cm)
            clock_throttle_control_q <=
                wdata[CM_EN_BIT:CM_DUTY_LSB];
    end

    mtm_clk_mod u_clk_mod
    (
        .mclk   (mclk),
        .nrst   (nrst),
        .enable (clock_throttle_control_q[CM_DUTY_W]),
        .duty   (clock_throttle_control_q[CM_DUTY_W-1:0]),
        .stop_q (clk_stop_q)
    );

    // ****************************************
    // Thermal interrupt control and status
    // ****************************************
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            thermal_irq_control_q <= TI_RST;
        else if (wr_ti)
            thermal_irq_control_q <= wdata[TI_LO_BIT:TI_HI_BIT];
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            hot_now_q <= 1'b0;
        else
            hot_now_q <= thermal_hot;
    end

    always_comb
    begin
        rise_hot = thermal_hot && !hot_now_q;
        fall_hot = !thermal_hot && hot_now_q;
    end

    // One copy serves every logical processor; log is write-zero-clear
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            hot_log_q <= 1'b0;
        else if (rise_hot)
            hot_log_q <= 1'b1;
        else if (clr_log)
            hot_log_q <= 1'b0;
    end

    // ****************************************
    // Second thermal monitor target
    // ****************************************
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            thermal_target_control_q <= TGT_RST;
        else if (wr_tgt)
            thermal_target_control_q <= wdata[TGT_W-1:0];
    end

    // ****************************************
    // Feature enables
    // ****************************************
    // Bit 1 reserved: forced to zero whatever is written
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            feature_enable_bits_q <= FE_RST;
        else if (wr_fe)
        begin
            feature_enable_bits_q[FE_FAST_BIT] <= wdata[FE_FAST_BIT];
            feature_enable_bits_q[1]           <= 1'b0;
            feature_enable_bits_q[FE_FOP_BIT]  <= wdata[FE_FOP_BIT];
        end
    end

    // ****************************************
    // Event interrupt
    // ****************************************
    always_comb
    begin
        events            = EV_RST;
        events[EV_MC_BIT] = mc_error;
        events[EV_DS_BIT] = ds_page_fault;
        events[EV_HI_BIT] = rise_hot &&
                            thermal_irq_control_q[TI_HI_BIT];
        events[EV_LO_BIT] = fall_hot &&
                            thermal_irq_control_q[TI_LO_BIT];
    end

    mtm_evt_irq u_evt_irq
    (
        .mclk       (mclk),
        .nrst       (nrst),
        .ev         (events),
        .stat_rd    (rd_stat),
        .mask_wr    (wr_mask),
        .mask_wdata (wdata[EV_W-1:0]),
        .stat_q     (evt_stat),
        .mask_q     (evt_mask),
        .irq_q      (irq_q)
    );

    // ****************************************
    // Read path
    // ****************************************
    // Unmapped offsets and reserved bits read as zero
    always_comb
    begin
        rd_mux = '0;
        unique case (addr)
            OFF_MC_FLAGS:
                rd_mux[SNAP_W-1:0] = mc_flags_snapshot_q;
            OFF_MC_IP:
                rd_mux[SNAP_W-1:0] = mc_ip_snapshot_q;
            OFF_MC_MISC:
                rd_mux[MISC_DS_BIT] = debug_store_fault_flag_q;
            OFF_CLK_THR:
                rd_mux[CM_EN_BIT:CM_DUTY_LSB] =
                    clock_throttle_control_q;
            OFF_THERM_IRQ:
                rd_mux[TI_LO_BIT:TI_HI_BIT] = thermal_irq_control_q;
            OFF_THERM_STAT:
            begin
                rd_mux[TS_HOT_BIT] = hot_now_q;
                rd_mux[TS_LOG_BIT] = hot_log_q;
            end
            OFF_THERM_TGT:
                rd_mux[TGT_W-1:0] = thermal_target_control_q;
            OFF_FEATURES:
                rd_mux[FE_FOP_BIT:0] = feature_enable_bits_q;
            OFF_EVT_STAT:
                rd_mux[EV_W-1:0] = evt_stat;
            OFF_EVT_MASK:
                rd_mux[EV_W-1:0] = evt_mask;
            default:
                rd_mux = '0;
        endcase
    end

    // Data valid only in the cycle after the strobe
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            rdata_q <= '0;
        else if (rd_stb)
            rdata_q <= rd_mux;
        else
            rdata_q <= '0;
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign rdata             = rdata_q;
    assign irq               = irq_q;
    assign shutdown_req      = shutdown_q;
    assign clk_stop          = clk_stop_q;
    assign thermal_target    = thermal_target_control_q;
    assign fast_strings_en   = feature_enable_bits_q[FE_FAST_BIT];
    assign fopcode_compat_en = feature_enable_bits_q[FE_FOP_BIT];

endmodule : mtm_bank
`default_nettype wire

//--- hw/mtm_clk_mod.sv
// On-demand clock modulation duty gate
`timescale 1ns/1ps
`default_nettype none
module mtm_clk_mod
    import mtm_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 nrst,
    input  wire logic                 enable,
    input  wire logic [CM_DUTY_W-1:0] duty,
    output logic                      stop_q
);

    logic [CM_DUTY_W-1:0] phase_q;

    // ****************************************
    // Phase counter
    // ****************************************
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            phase_q <= '0;
        else
            phase_q <= phase_q + 1'b1;
    end

    // Duty of zero is treated as full run, never a stuck clock
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            stop_q <= 1'b0;
        else
            stop_q <= enable && (duty != '0) && (phase_q >= duty);
    end

endmodule : mtm_clk_mod
`default_nettype wire

//--- hw/mtm_evt_irq.sv
// Sticky event status, mask and level interrupt
`timescale 1ns/1ps
`default_nettype none
module mtm_evt_irq
    import mtm_pkg::*;
(
    input  wire logic            mclk,
    input  wire logic            nrst,
    input  wire logic [EV_W-1:0] ev,
    input  wire logic            stat_rd,
    input  wire logic            mask_wr,
    input  wire logic [EV_W-1:0] mask_wdata,
    output logic      [EV_W-1:0] stat_q,
    output logic      [EV_W-1:0] mask_q,
    output logic                 irq_q
);

    logic [EV_W-1:0] stat_d;
    logic [EV_W-1:0] mask_d;

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        // New event beats the read that clears
        stat_d = (stat_rd ? EV_RST : stat_q) | ev;
        mask_d = mask_wr ? mask_wdata : mask_q;
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            stat_q <= EV_RST;
            mask_q <= EV_RST;
            irq_q  <= 1'b0;
        end
        else
        begin
            stat_q <= stat_d;
            mask_q <= mask_d;
            // Next values used so irq tracks status with no extra lag
            irq_q  <= |(stat_d & mask_d);
        end
    end

endmodule : mtm_evt_irq
`default_nettype wire

//--- hw/mtm_pkg.sv
// Package: constants for the thermal and machine-check register bank
package mtm_pkg;

    // ****************************************
    // Bus shape
    // ****************************************
    localparam int ADDR_W = 10;
    localparam int DATA_W = 64;
    localparam int SNAP_W = 32;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [ADDR_W-1:0] OFF_MC_FLAGS   = 10'h188;
    localparam logic [ADDR_W-1:0] OFF_MC_IP      = 10'h189;
    localparam logic [ADDR_W-1:0] OFF_MC_MISC    = 10'h18a;
    localparam logic [ADDR_W-1:0] OFF_CLK_THR    = 10'h19a;
    localparam logic [ADDR_W-1:0] OFF_THERM_IRQ  = 10'h19b;
    localparam logic [ADDR_W-1:0] OFF_THERM_STAT = 10'h19c;
    localparam logic [ADDR_W-1:0] OFF_THERM_TGT  = 10'h19d;
    localparam logic [ADDR_W-1:0] OFF_FEATURES   = 10'h1a0;
    localparam logic [ADDR_W-1:0] OFF_EVT_STAT   = 10'h1b0;
    localparam logic [ADDR_W-1:0] OFF_EVT_MASK   = 10'h1b1;

    // ****************************************
    // Field positions and widths
    // ****************************************
    localparam int MISC_DS_BIT  = 0;
    localparam int CM_EN_BIT    = 4;
    localparam int CM_DUTY_LSB  = 1;
    localparam int CM_DUTY_W    = 3;
    localparam int TI_HI_BIT    = 0;
    localparam int TI_LO_BIT    = 1;
    localparam int TS_HOT_BIT   = 0;
    localparam int TS_LOG_BIT   = 1;
    localparam int TGT_W        = 16;
    localparam int FE_FAST_BIT  = 0;
    localparam int FE_FOP_BIT   = 2;

    // ****************************************
    // Interrupt events
    // ****************************************
    localparam int EV_W        = 4;
    localparam int EV_MC_BIT   = 0;
    localparam int EV_DS_BIT   = 1;
    localparam int EV_HI_BIT   = 2;
    localparam int EV_LO_BIT   = 3;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [SNAP_W-1:0]    SNAP_RST  = 32'h0000_0000;
    localparam logic [CM_DUTY_W:0]   CM_RST    = 4'h0;
    localparam logic [1:0]           TI_RST    = 2'h0;
    localparam logic [TGT_W-1:0]     TGT_RST   = 16'h0000;
    localparam logic [FE_FOP_BIT:0]  FE_RST    = 3'h1;
    localparam logic [EV_W-1:0]      EV_RST    = 4'h0;

    // Software may clear captured bits but never set them
    function automatic logic [SNAP_W-1:0] clear_only(
        input logic [SNAP_W-1:0] cur,
        input logic [SNAP_W-1:0] wr
    );
        clear_only = cur & wr;
    endfunction : clear_only

endpackage : mtm_pkg

//--- testbench/mtm_bank_monitor.sv
// Concurrent checks on the register bank ports
`timescale 1ns/1ps
`default_nettype none
module mtm_bank_monitor
    import mtm_pkg::*;
(
    input wire logic              mclk,
    input wire logic              nrst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic              wr_stb,
    input wire logic              rd_stb,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic              ds_page_fault,
    input wire logic              shutdown_req,
    input wire logic [TGT_W-1:0]  thermal_target,
    input wire logic              fast_strings_en,
    input wire logic              fopcode_compat_en
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // ******
    // Checks
    // ******
    rd_idle_a:
    assert property (!rd_stb |=> rdata == '0)
        else $error("read data not zero outside a read");
    flags_rsvd_a:
    assert property (rd_stb && addr == OFF_MC_FLAGS |=> rdata[63:32] == '0)
        else $error("flags snapshot upper bits set");
    ip_rsvd_a:
    assert property (rd_stb && addr == OFF_MC_IP |=> rdata[63:32] == '0)
        else $error("ip snapshot upper bits set");
    misc_rsvd_a:
    assert property (rd_stb && addr == OFF_MC_MISC |=> rdata[63:1] == '0)
        else $error("misc reserved bits set");
    fault_shut_a:
    assert property (ds_page_fault |=> shutdown_req)
        else $error("fault did not raise shutdown");
    shut_hold_a:
    assert property (shutdown_req && !(wr_stb && addr == OFF_MC_MISC)
        && !$past(wr_stb && addr == OFF_MC_MISC) |=> shutdown_req)
        else $error("shutdown dropped without clear");
    fault_clear_a:
    assert property ((wr_stb && addr == OFF_MC_MISC && !wdata[0]
        && !ds_page_fault) ##1 !ds_page_fault |=> !shutdown_req)
        else $error("shutdown stayed after clear");
    tgt_load_a:
    assert property (wr_stb && addr == OFF_THERM_TGT
        |=> thermal_target == $past(wdata[TGT_W-1:0]))
        else $error("target output not loaded");
    fe_load_a:
    assert property (wr_stb && addr == OFF_FEATURES |=> fast_strings_en
        == $past(wdata[0]) && fopcode_compat_en == $past(wdata[2]))
        else $error("feature outputs not loaded");
    fe_hold_a:
    assert property (!(wr_stb && addr == OFF_FEATURES)
        |=> $stable(fast_strings_en) && $stable(fopcode_compat_en))
        else $error("feature outputs moved without write");
endmodule : mtm_bank_monitor

bind mtm_bank mtm_bank_monitor mtm_bank_monitor_inst (
    .mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .ds_page_fault(ds_page_fault), .shutdown_req(shutdown_req),
    .thermal_target(thermal_target), .fast_strings_en(fast_strings_en),
    .fopcode_compat_en(fopcode_compat_en)
);
`default_nettype wire

//--- testbench/mtm_bank_tb_top.sv
// Self-checking bench for the register bank
`timescale 1ns/1ps
`default_nettype none
module mtm_bank_tb_top import mtm_pkg::*;;
    logic              mclk = 1'b0;
    logic              nrst = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic              wr_stb = 1'b0;
    logic              rd_stb = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic              mc_error = 1'b0;
    logic [SNAP_W-1:0] flags_in = '0;
    logic [SNAP_W-1:0] ip_in = '0;
    logic              ds_fault = 1'b0;
    logic              hot = 1'b0;
    logic              irq, shut, stop, fast, fop;
    logic [TGT_W-1:0]  tgt;
    logic [DATA_W-1:0] exp_q[$];
    logic              rd_seen = 1'b0;
    logic [31:0]       seed = 32'h0001_3860;
    int                failures = 0;
    int                comparisons = 0;
    int                n_stop;

    mtm_bank mtm_bank_inst (
        .mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .mc_error(mc_error), .flags_word_in(flags_in),
        .instruction_pointer_in(ip_in), .ds_page_fault(ds_fault),
        .thermal_hot(hot), .irq(irq), .shutdown_req(shut),
        .clk_stop(stop), .thermal_target(tgt),
        .fast_strings_en(fast), .fopcode_compat_en(fop)
    );

    initial forever #10 mclk = ~mclk;

    // ******
    // Helpers
    // ******
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic check(input logic [63:0] got, input logic [63:0] exp,
                         input string msg);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: %s got %h exp %h",
                     $time, msg, got, exp);
        end
    endtask : check

    // Strobes stay put until the next call, so no double assignment
    task automatic bus(input logic w, input logic r,
                       input logic [ADDR_W-1:0] a, input logic [63:0] d);
        @(posedge mclk);
        wr_stb <= w;
        rd_stb <= r;
        addr <= a;
        wdata <= d;
    endtask : bus

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [63:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [63:0] e);
        exp_q.push_back(e);
        bus(1'b0, 1'b1, a, '0);
    endtask : rd

    task automatic idle(input int n);
        repeat (n) bus(1'b0, 1'b0, '0, '0);
        @(negedge mclk);
    endtask : idle

    task automatic pulse(input logic m, input logic d);
        bus(1'b0, 1'b0, '0, '0);
        mc_error <= m;
        ds_fault <= d;
        @(posedge mclk);
        mc_error <= 1'b0;
        ds_fault <= 1'b0;
    endtask : pulse

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask : done

    task automatic give_verdict;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict

    // Read data only stands one cycle, so sample it at the mid point
    always @(posedge mclk) rd_seen <= rd_stb;
    always @(negedge mclk)
        if (rd_seen)
            check(rdata, exp_q.pop_front(), "read data");

    initial
    begin
        repeat (20000) @(posedge mclk);
        failures++;
        give_verdict;
    end

    // ******
    // Tests
    // ******
    initial
    begin
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
        idle(1);
        check({fast, fop, irq, shut, stop}, 64'h10, "reset pins");
        rd(OFF_FEATURES, 64'h1);
        rd(OFF_THERM_TGT, 64'h0);
        rd(OFF_MC_FLAGS, 64'h0);
        rd(OFF_EVT_MASK, 64'h0);
        done("reset");
        wr(OFF_FEATURES, '1);
        rd(OFF_FEATURES, 64'h5);
        idle(1);
        check({fast, fop}, 64'h3, "feature pins");
        wr(OFF_FEATURES, 64'h2);
        rd(OFF_FEATURES, 64'h0);
        idle(1);
        check({fast, fop}, 64'h0, "feature pins");
        wr(OFF_FEATURES, 64'h1);
        repeat (4)
        begin
            seed = lfsr(seed);
            wr(OFF_THERM_TGT, {seed, seed});
            rd(OFF_THERM_TGT, {48'h0, seed[15:0]});
        end
        idle(1);
        check({48'h0, tgt}, {48'h0, seed[15:0]}, "target pins");
        done("features and target");
        seed = lfsr(seed);
        @(posedge mclk);
        flags_in <= seed;
        ip_in <= ~seed;
        pulse(1'b1, 1'b0);
        idle(1);
        check({63'h0, irq}, 64'h0, "masked irq");
        rd(OFF_EVT_STAT, 64'h1);
        rd(OFF_EVT_STAT, 64'h0);
        wr(OFF_EVT_MASK, 64'h1);
        pulse(1'b1, 1'b0);
        idle(1);
        check({63'h0, irq}, 64'h1, "event irq");
        rd(OFF_MC_FLAGS, {32'h0, seed});
        rd(OFF_MC_IP, {32'h0, ~seed});
        wr(OFF_MC_FLAGS, {32'hffff_ffff, 32'h0f0f_0f0f});
        wr(OFF_MC_IP, 64'h0);
        rd(OFF_MC_FLAGS, {32'h0, seed & 32'h0f0f_0f0f});
        rd(OFF_MC_IP, 64'h0);
        rd(OFF_EVT_STAT, 64'h1);
        idle(2);
        check({63'h0, irq}, 64'h0, "irq after read");
        done("snapshots");
        wr(OFF_EVT_MASK, 64'h2);
        pulse(1'b0, 1'b1);
        idle(1);
        check({shut, irq}, 64'h3, "fault pins");
        rd(OFF_MC_MISC, 64'h1);
        wr(OFF_MC_MISC, '1);
        rd(OFF_MC_MISC, 64'h1);
        wr(OFF_MC_MISC, 64'h0);
        rd(OFF_MC_MISC, 64'h0);
        rd(OFF_EVT_STAT, 64'h2);
        idle(2);
        check({shut, irq}, 64'h0, "fault cleared");
        done("debug store fault");
        wr(OFF_THERM_IRQ, '1);
        rd(OFF_THERM_IRQ, 64'h3);
        wr(OFF_EVT_MASK, 64'hc);
        hot <= 1'b1;
        idle(3);
        rd(OFF_THERM_STAT, 64'h3);
        rd(OFF_EVT_STAT, 64'h4);
        hot <= 1'b0;
        idle(3);
        rd(OFF_THERM_STAT, 64'h2);
        rd(OFF_EVT_STAT, 64'h8);
        wr(OFF_THERM_STAT, 64'h0);
        rd(OFF_THERM_STAT, 64'h0);
        wr(OFF_THERM_IRQ, 64'h0);
        rd(OFF_THERM_IRQ, 64'h0);
        hot <= 1'b1;
        idle(3);
        rd(OFF_EVT_STAT, 64'h0);
        done("thermal");
        // Eight full phase rounds, so alignment does not matter
        for (int n = 0; n < 9; n++)
        begin
            wr(OFF_CLK_THR, {{59{1'b1}}, n < 8, 3'(n), 1'b1});
            rd(OFF_CLK_THR, {59'h0, n < 8, 3'(n), 1'b0});
            idle(4);
            n_stop = 0;
            repeat (64)
            begin
                @(negedge mclk);
                n_stop += int'(stop);
            end
            check(64'(n_stop), 64'((n % 8 == 0) ? 0 : 8 * (8 - n)),
                  "stop count");
        end
        done("clock modulation");
        wr(10'h100, '1);
        rd(10'h100, 64'h0);
        rd(10'h1a1, 64'h0);
        wr(OFF_FEATURES, 64'h4);
        idle(1);
        @(posedge mclk);
        nrst <= 1'b0;
        idle(2);
        @(posedge mclk);
        nrst <= 1'b1;
        idle(1);
        check({tgt, fast, fop, shut}, 64'h4, "second reset");
        done("unmapped and reset");
        idle(2);
        give_verdict;
    end
endmodule : mtm_bank_tb_top
`default_nettype wire
